// ==== src/cprc_pkg.sv ====
// Constants for the codec power and sample-rate control register bank.
// Assumes AXI4-Lite register access with 32-bit data and byte addresses.
//
// How it works
// RULE1: Power bit 10 steers the audio processing input to the converters when clear, to the digital microphone when set.
// RULE2: Software sets the left and right input converter enables whenever the digital microphone is chosen.
// RULE3: Power bit 9 drives the enable of the divided clock on the general purpose pin.
// RULE4: Bits 8:7 pick reference off, 50k normal, 250k standby or 5k fast start divider.
// RULE5: Bits 5 and 4 enable the left and right input gain and mixer, bits 3 and 2 the input converters.
// RULE6: Bit 6 enables the normal bias generator and bit 1 the mic bias, whose output floats when clear.
// RULE7: Software sets the output converter enables while a channel carries playback or beep data.
// RULE8: Output bits 6 and 5 enable the headphone gain stages and bits 4 and 3 the speaker gain stages.
// RULE9: Output bits 1 and 0 mute the left and right headphone gain stages while set.
// RULE10: Rate bit 4, reset high, picks the integer family when set and the fractional family when clear.
// RULE11: Rate bits 2:0 decode to seven sample rates, code 111 being reserved.
// RULE12: Anti-pop bits 4, 3 and 2 enable start-up bias, reference buffer and reference soft ramp.
// RULE13: Mic bias level bits 1:0 hand over to the fine level at 00, pick 1.63x at 01 or 11 and 1.34x at 10.
// RULE14: Undefined bits read as zero and ignore writes.
package cprc_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [5:0] CPRC_IDX_PWR_IN = 6'h19;
  localparam logic [5:0] CPRC_IDX_PWR_OUT = 6'h1A;
  localparam logic [5:0] CPRC_IDX_RATE = 6'h1B;
  localparam logic [5:0] CPRC_IDX_ANTIPOP = 6'h1C;
  localparam logic [5:0] CPRC_IDX_MICLVL = 6'h1D;
  localparam int CPRC_REG_COUNT = 5;
  localparam logic [2:0] CPRC_SEL_PWR_IN = 3'h0;
  localparam logic [2:0] CPRC_SEL_PWR_OUT = 3'h1;
  localparam logic [2:0] CPRC_SEL_RATE = 3'h2;
  localparam logic [2:0] CPRC_SEL_ANTIPOP = 3'h3;
  localparam logic [2:0] CPRC_SEL_MICLVL = 3'h4;
  localparam int CPRC_ADDR_W = 8;

  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [15:0] CPRC_MASK [CPRC_REG_COUNT] =
    '{16'h07FE, 16'h01FB, 16'h0017, 16'h001C, 16'h0003};
  localparam logic [15:0] CPRC_RESET [CPRC_REG_COUNT] =
    '{16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0000};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CPRC_DIGITAL_MIC_SELECT = 10;
  localparam int CPRC_GPIO_CLOCK_OUT_ENABLE = 9;
  localparam int CPRC_REF_DIV_SEL_LSB = 7;
  localparam int CPRC_NORMAL_BIAS_ENABLE = 6;
  localparam int CPRC_LEFT_INPUT_PATH_ENABLE = 5;
  localparam int CPRC_RIGHT_INPUT_PATH_ENABLE = 4;
  localparam int CPRC_LEFT_CONV_IN_ENABLE = 3;
  localparam int CPRC_RIGHT_CONV_IN_ENABLE = 2;
  localparam int CPRC_MIC_BIAS_ENABLE = 1;
  localparam int CPRC_LEFT_CONV_OUT_ENABLE = 8;
  localparam int CPRC_RIGHT_CONV_OUT_ENABLE = 7;
  localparam int CPRC_LEFT_HP_GAIN_ENABLE = 6;
  localparam int CPRC_RIGHT_HP_GAIN_ENABLE = 5;
  localparam int CPRC_LEFT_SPK_GAIN_ENABLE = 4;
  localparam int CPRC_RIGHT_SPK_GAIN_ENABLE = 3;
  localparam int CPRC_LEFT_HP_GAIN_MUTE = 1;
  localparam int CPRC_RIGHT_HP_GAIN_MUTE = 0;
  localparam int CPRC_RATE_INT_MODE = 4;
  localparam int CPRC_RATE_CODE_LSB = 0;
  localparam int CPRC_STARTUP_BIAS_ENABLE = 4;
  localparam int CPRC_REF_BUFFER_ENABLE = 3;
  localparam int CPRC_REF_SOFT_RAMP_ENABLE = 2;
  localparam int CPRC_MIC_BIAS_LEVEL_LSB = 0;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] CPRC_REF_OFF = 2'h0;
  localparam logic [1:0] CPRC_REF_50K = 2'h1;
  localparam logic [1:0] CPRC_REF_250K = 2'h2;
  localparam logic [1:0] CPRC_REF_5K = 2'h3;
  localparam logic [2:0] CPRC_RATE_RESERVED = 3'h7;
  localparam logic [1:0] CPRC_MICLVL_FINE = 2'h0;
  localparam logic [1:0] CPRC_MICLVL_134 = 2'h2;
  localparam logic [1:0] CPRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPRC_RESP_DECERR = 2'h3;

endpackage

// ==== src/cprc_wr_if.sv ====
// Write port shared between the bus slave and each register cell.
// Assumes a single clock domain.
`timescale 1ns/10ps
interface cprc_wr_if;
  logic we;
  logic [2:0] sel;
  logic [15:0] data;
  logic [1:0] strb;
  modport master (output we, sel, data, strb);
  modport slave (input we, sel, data, strb);
endinterface

// ==== src/cprc_reg_cell.sv ====
// One 16-bit control register with a writable mask and byte strobes.
// Assumes writes come through the shared write port.
`timescale 1ns/10ps
module cprc_reg_cell
  import cprc_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] RESET = 16'h0000,
  parameter logic [2:0] SEL = 3'h0
)
(
  input wire logic aclk,
  input wire logic aresetn,
  cprc_wr_if.slave wr,
  output logic [15:0] value
);

  logic [15:0] lane_mask;

  assign lane_mask = {{8{wr.strb[1]}}, {8{wr.strb[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      value <= RESET;
    end
    else if (wr.we && (wr.sel == SEL))
    begin
      value <= ((wr.data & lane_mask) | (value & ~lane_mask)) & MASK; // RULE14
    end
  end

endmodule

// ==== src/cprc_regs.sv ====
// Power, reference, rate and mic bias control bank behind an AXI4-Lite slave.
// Assumes one master with at most one write and one read outstanding.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
module cprc_regs
  import cprc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic digital_mic_select,
  output logic dsp_input_from_converters,
  output logic gpio_clock_out_enable,
  output logic [1:0] reference_divider_select,
  output logic reference_off,
  output logic reference_div_normal,
  output logic reference_div_standby,
  output logic reference_div_fast,
  output logic normal_bias_enable,
  output logic left_input_path_enable,
  output logic right_input_path_enable,
  output logic left_converter_in_enable,
  output logic right_converter_in_enable,
  output logic mic_bias_enable,
  output logic mic_bias_output_hiz,
  output logic left_converter_out_enable,
  output logic right_converter_out_enable,
  output logic left_headphone_gain_enable,
  output logic right_headphone_gain_enable,
  output logic left_speaker_gain_enable,
  output logic right_speaker_gain_enable,
  output logic left_headphone_gain_mute,
  output logic right_headphone_gain_mute,
  output logic rate_integer_family,
  output logic [2:0] sample_rate_code,
  output logic rate_48k,
  output logic rate_32k,
  output logic rate_24k,
  output logic rate_16k,
  output logic rate_12k,
  output logic rate_8k,
  output logic rate_96k,
  output logic rate_code_reserved,
  output logic startup_bias_enable,
  output logic reference_buffer_enable,
  output logic reference_soft_ramp_enable,
  output logic [1:0] mic_bias_level_select,
  output logic mic_bias_use_fine_level,
  output logic mic_bias_level_high,
  output logic mic_bias_level_low
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  cprc_wr_if wr ();

  logic [15:0] reg_value [CPRC_REG_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < CPRC_REG_COUNT; gi++)
    begin : g_cell
      cprc_reg_cell #(
        .MASK(CPRC_MASK[gi]),
        .RESET(CPRC_RESET[gi]),
        .SEL(3'(gi))
      ) u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr(wr),
        .value(reg_value[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr[1:0] == 2'h0) && (addr[7:2] >= CPRC_IDX_PWR_IN)
      && (addr[7:2] <= CPRC_IDX_MICLVL);
  endfunction

  function automatic logic [2:0] addr_sel(input logic [7:0] addr);
    logic [5:0] diff;
    diff = addr[7:2] - CPRC_IDX_PWR_IN;
    addr_sel = diff[2:0];
  endfunction

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic write_go;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign write_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      awaddr_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (write_go)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      wdata_q <= s_axi_wdata[15:0];
      wstrb_q <= s_axi_wstrb[1:0];
    end
    else if (write_go)
    begin
      w_held <= 1'b0;
    end
  end

  assign wr.we = write_go && addr_hit(awaddr_q);
  assign wr.sel = addr_sel(awaddr_q);
  assign wr.data = wdata_q;
  assign wr.strb = wstrb_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CPRC_RESP_OKAY;
    end
    else if (write_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_hit(awaddr_q) ? CPRC_RESP_OKAY : CPRC_RESP_DECERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CPRC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      if (addr_hit(s_axi_araddr))
      begin
        s_axi_rdata <= {16'h0000, reg_value[addr_sel(s_axi_araddr)]}; // RULE14
        s_axi_rresp <= CPRC_RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= CPRC_RESP_DECERR;
      end
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Direct control fields
  // ----------------------------------------
  logic [15:0] pin;
  logic [15:0] pout;
  logic [15:0] prate;
  logic [15:0] papop;
  logic [15:0] pmic;

  assign pin = reg_value[CPRC_SEL_PWR_IN];
  assign pout = reg_value[CPRC_SEL_PWR_OUT];
  assign prate = reg_value[CPRC_SEL_RATE];
  assign papop = reg_value[CPRC_SEL_ANTIPOP];
  assign pmic = reg_value[CPRC_SEL_MICLVL];

  assign digital_mic_select = pin[CPRC_DIGITAL_MIC_SELECT]; // RULE1
  assign gpio_clock_out_enable = pin[CPRC_GPIO_CLOCK_OUT_ENABLE]; // RULE3
  assign reference_divider_select = pin[CPRC_REF_DIV_SEL_LSB +: 2];
  assign normal_bias_enable = pin[CPRC_NORMAL_BIAS_ENABLE]; // RULE6
  assign left_input_path_enable = pin[CPRC_LEFT_INPUT_PATH_ENABLE]; // RULE5
  assign right_input_path_enable = pin[CPRC_RIGHT_INPUT_PATH_ENABLE]; // RULE5
  assign left_converter_in_enable = pin[CPRC_LEFT_CONV_IN_ENABLE]; // RULE5
  assign right_converter_in_enable = pin[CPRC_RIGHT_CONV_IN_ENABLE]; // RULE5
  assign mic_bias_enable = pin[CPRC_MIC_BIAS_ENABLE]; // RULE6
  assign left_converter_out_enable = pout[CPRC_LEFT_CONV_OUT_ENABLE];
  assign right_converter_out_enable = pout[CPRC_RIGHT_CONV_OUT_ENABLE];
  assign left_headphone_gain_enable = pout[CPRC_LEFT_HP_GAIN_ENABLE]; // RULE8
  assign right_headphone_gain_enable = pout[CPRC_RIGHT_HP_GAIN_ENABLE]; // RULE8
  assign left_speaker_gain_enable = pout[CPRC_LEFT_SPK_GAIN_ENABLE]; // RULE8
  assign right_speaker_gain_enable = pout[CPRC_RIGHT_SPK_GAIN_ENABLE]; // RULE8
  assign left_headphone_gain_mute = pout[CPRC_LEFT_HP_GAIN_MUTE]; // RULE9
  assign right_headphone_gain_mute = pout[CPRC_RIGHT_HP_GAIN_MUTE]; // RULE9
  assign rate_integer_family = prate[CPRC_RATE_INT_MODE]; // RULE10
  assign sample_rate_code = prate[CPRC_RATE_CODE_LSB +: 3];
  assign startup_bias_enable = papop[CPRC_STARTUP_BIAS_ENABLE]; // RULE12
  assign reference_buffer_enable = papop[CPRC_REF_BUFFER_ENABLE]; // RULE12
  assign reference_soft_ramp_enable = papop[CPRC_REF_SOFT_RAMP_ENABLE]; // RULE12
  assign mic_bias_level_select = pmic[CPRC_MIC_BIAS_LEVEL_LSB +: 2];

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dsp_input_from_converters <= 1'b1;
    end
    else
    begin
      dsp_input_from_converters <= !pin[CPRC_DIGITAL_MIC_SELECT]; // RULE1
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mic_bias_output_hiz <= 1'b1;
    end
    else
    begin
      mic_bias_output_hiz <= !pin[CPRC_MIC_BIAS_ENABLE]; // RULE6
    end
  end

  // ----------------------------------------
  // Reference divider decode
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reference_off <= 1'b1;
      reference_div_normal <= 1'b0;
      reference_div_standby <= 1'b0;
      reference_div_fast <= 1'b0;
    end
    else
    begin
      reference_off <= (reference_divider_select == CPRC_REF_OFF); // RULE4
      reference_div_normal <= (reference_divider_select == CPRC_REF_50K); // RULE4
      reference_div_standby <= (reference_divider_select == CPRC_REF_250K); // RULE4
      reference_div_fast <= (reference_divider_select == CPRC_REF_5K); // RULE4
    end
  end

  // ----------------------------------------
  // Sample rate decode
  // ----------------------------------------
  logic [7:0] next_rate_onehot;

  always_comb
  begin
    next_rate_onehot = 8'h00;
    next_rate_onehot[sample_rate_code] = 1'b1; // RULE11
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {rate_code_reserved, rate_96k, rate_8k, rate_12k, rate_16k, rate_24k, rate_32k,
        rate_48k} <= 8'h01;
    end
    else
    begin
      {rate_code_reserved, rate_96k, rate_8k, rate_12k, rate_16k, rate_24k, rate_32k,
        rate_48k} <= next_rate_onehot; // RULE11
    end
  end

  // ----------------------------------------
  // Mic bias level decode
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mic_bias_use_fine_level <= 1'b1;
      mic_bias_level_high <= 1'b0;
      mic_bias_level_low <= 1'b0;
    end
    else
    begin
      mic_bias_use_fine_level <= (mic_bias_level_select == CPRC_MICLVL_FINE); // RULE13
      mic_bias_level_low <= (mic_bias_level_select == CPRC_MICLVL_134); // RULE13
      mic_bias_level_high <= mic_bias_level_select[0]; // RULE13
    end
  end

endmodule

// ==== tb/cprc_regs_props.sv ====
// Port checks for the control register bank.
// Bound into the bank; one clock, reset synchronous and active low.
`timescale 1ns/10ps
module cprc_regs_props
  import cprc_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic digital_mic_select,
  input logic dsp_input_from_converters,
  input logic [1:0] reference_divider_select,
  input logic reference_off,
  input logic reference_div_normal,
  input logic reference_div_standby,
  input logic reference_div_fast,
  input logic mic_bias_enable,
  input logic mic_bias_output_hiz,
  input logic rate_integer_family,
  input logic [2:0] sample_rate_code,
  input logic rate_48k,
  input logic rate_32k,
  input logic rate_24k,
  input logic rate_16k,
  input logic rate_12k,
  input logic rate_8k,
  input logic rate_96k,
  input logic rate_code_reserved,
  input logic [1:0] mic_bias_level_select,
  input logic mic_bias_use_fine_level,
  input logic mic_bias_level_high,
  input logic mic_bias_level_low
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wans;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wtake |=> s_wans)
    else $error("write answer not two cycles after take");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after take");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped early");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  a_dsp_source: assert property ($past(aresetn) |->
    dsp_input_from_converters == !$past(digital_mic_select)) else $error("source wrong");
  a_bias_float: assert property ($past(aresetn) |->
    mic_bias_output_hiz == !$past(mic_bias_enable)) else $error("bias float wrong");
  a_ref_decode: assert property ($past(aresetn) |->
    {reference_div_fast, reference_div_standby, reference_div_normal, reference_off} ==
    4'h1 << $past(reference_divider_select)) else $error("divider decode wrong");
  a_rate_decode: assert property ($past(aresetn) |->
    {rate_code_reserved, rate_96k, rate_8k, rate_12k, rate_16k, rate_24k, rate_32k,
    rate_48k} == 8'h01 << $past(sample_rate_code)) else $error("rate decode wrong");
  a_mic_level: assert property ($past(aresetn) |->
    {mic_bias_level_low, mic_bias_level_high, mic_bias_use_fine_level} ==
    {$past(mic_bias_level_select) == 2'h2, $past(mic_bias_level_select) inside {2'h1, 2'h3},
    $past(mic_bias_level_select) == 2'h0}) else $error("mic level decode wrong");
  a_rate_reset: assert property ($rose(aresetn) |-> rate_integer_family)
    else $error("rate family not set after reset");
endmodule
bind cprc_regs cprc_regs_props u_cprc_regs_props (.*);

// ==== tb/cprc_regs_test.sv ====
// Self-checking bench for the control register bank.
// Drives the AXI4-Lite port itself and watches every control output.
`timescale 1ns/10ps
module cprc_regs_test
  import cprc_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_divider_select, mic_bias_level_select;
  logic [2:0] sample_rate_code;
  logic digital_mic_select, dsp_input_from_converters, gpio_clock_out_enable;
  logic reference_off, reference_div_normal, reference_div_standby, reference_div_fast;
  logic normal_bias_enable, left_input_path_enable, right_input_path_enable;
  logic left_converter_in_enable, right_converter_in_enable, mic_bias_enable;
  logic mic_bias_output_hiz, left_converter_out_enable, right_converter_out_enable;
  logic left_headphone_gain_enable, right_headphone_gain_enable;
  logic left_speaker_gain_enable, right_speaker_gain_enable;
  logic left_headphone_gain_mute, right_headphone_gain_mute, rate_integer_family;
  logic rate_48k, rate_32k, rate_24k, rate_16k, rate_12k, rate_8k, rate_96k;
  logic rate_code_reserved, startup_bias_enable, reference_buffer_enable;
  logic reference_soft_ramp_enable, mic_bias_use_fine_level;
  logic mic_bias_level_high, mic_bias_level_low;
  logic [15:0] m [5];
  logic [33:0] qr [$];
  logic [1:0] qb [$];
  logic [31:0] x = 32'h92DD;
  int n_errors = 0, n_checks = 0;
  wire [26:0] ov = {digital_mic_select, gpio_clock_out_enable, reference_divider_select,
    normal_bias_enable, left_input_path_enable, right_input_path_enable,
    left_converter_in_enable, right_converter_in_enable, mic_bias_enable,
    left_converter_out_enable, right_converter_out_enable, left_headphone_gain_enable,
    right_headphone_gain_enable, left_speaker_gain_enable, right_speaker_gain_enable,
    left_headphone_gain_mute, right_headphone_gain_mute, rate_integer_family,
    sample_rate_code, startup_bias_enable, reference_buffer_enable,
    reference_soft_ramp_enable, mic_bias_level_select};

  wire [16:0] dv = {dsp_input_from_converters, mic_bias_output_hiz, reference_div_fast,
    reference_div_standby, reference_div_normal, reference_off, rate_code_reserved, rate_96k,
    rate_8k, rate_12k, rate_16k, rate_24k, rate_32k, rate_48k, mic_bias_level_low,
    mic_bias_level_high, mic_bias_use_fine_level};

  cprc_regs u_cprc_regs (.*);

  initial
  begin
    forever #4 aclk = ~aclk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [26:0] eo();
    return {m[0][10:1], m[1][8:3], m[1][1:0], m[2][4], m[2][2:0], m[3][4:2], m[4][1:0]};
  endfunction
  function automatic logic [16:0] ed();
    return {!m[0][10], !m[0][1], 4'h1 << m[0][8:7], 8'h01 << m[2][2:0],
      m[4][1:0] == 2'h2, m[4][1:0] inside {2'h1, 2'h3}, m[4][1:0] == 2'h0};
  endfunction
  task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    logic ta, tw, g;
    int n;
    n = 0;
    qb.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      g = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      s_axi_bready <= !g && n > 1;
      n++;
    end
    while (!g);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic t, g;
    int n;
    n = 0;
    qr.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = s_axi_arvalid && s_axi_arready;
      g = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (t)
        s_axi_arvalid <= 1'b0;
      s_axi_rready <= !g && n > 1;
      n++;
    end
    while (!g);
  endtask
  task automatic co();
    chk("outs", {7'h0, eo()}, {7'h0, ov});
    chk("decoded", {17'h0, ed()}, {17'h0, dv});
  endtask
  task automatic wm(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] b;
    b = {{8{s[1]}}, {8{s[0]}}} & CPRC_MASK[i];
    wr(8'h64 + 8'(4 * i), d, s, CPRC_RESP_OKAY);
    m[i] = (m[i] & ~b) | (d[15:0] & b);
    co();
  endtask
  task automatic rall();
    for (int i = 0; i < 5; i++)
      rd(8'h64 + 8'(4 * i), {CPRC_RESP_OKAY, 16'h0, m[i]});
  endtask
  task automatic rst(input int k);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (k) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      m[i] = CPRC_RESET[i];
    rall();
    co();
  endtask
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(negedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", qr.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {32'h0, qb.pop_front()}, {32'h0, s_axi_bresp});
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    logic [31:0] r;
    rst(16);
    $display("test reset values done");
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 5; i++)
        wm(i, k ? 32'h0 : 32'hFFFFFFFF, 4'hF);
      rall();
    end
    $display("test full masks done");
    for (int c = 0; c < 8; c++)
    begin
      wm(0, 32'(c) << 7, 4'h3);
      wm(2, 32'(c) | (32'(c & 1) << 4), 4'h1);
      wm(4, 32'(c), 4'h1);
    end
    $display("test codes done");
    repeat (40)
    begin
      r = xs();
      wm(int'(r[2:0]) % 5, xs(), r[7:4]);
    end
    rall();
    $display("test random writes done");
    rd(8'h78, {CPRC_RESP_DECERR, 32'h0});
    rd(8'h66, {CPRC_RESP_DECERR, 32'h0});
    wr(8'h60, xs(), 4'hF, CPRC_RESP_DECERR);
    wr(8'h65, xs(), 4'hF, CPRC_RESP_DECERR);
    rall();
    co();
    $display("test unmapped done");
    rst(2);
    $display("test second reset done");
    results();
  end
  initial
  begin
    #200000;
    n_errors++;
    results();
  end
endmodule
